// ===== bench/sub_path_monitor.sv
// port-level checker of the subtract path
`timescale 1ns/100ps
module sub_path_monitor (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        instr_valid,
   input wire logic [13:0] instr_word,
   input wire logic [7:0]  file_rd_data,
   input wire logic [6:0]  file_addr,
   input wire logic        file_rd_en,
   input wire logic        file_wr_en,
   input wire logic [7:0]  file_wr_data,
   input wire logic [7:0]  acc,
   input wire logic        carry_flag,
   input wire logic        half_byte_carry_flag,
   input wire logic        zero_flag,
   input wire logic        done,
   input wire logic [1:0]  phase
);
   // ==================================================
   // helpers
   logic tl, tf, lit_ge, lit_lo_ge;
   assign tl = phase == 2'h0 && instr_valid && instr_word[13:9] == 5'b11110;
   assign tf = phase == 2'h0 && instr_valid && instr_word[13:8] == 6'h02;
   assign lit_ge = instr_word[7:0] >= acc;
   assign lit_lo_ge = instr_word[3:0] >= acc[3:0];
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // ==================================================
   // assertions
   phase_order_a: assert property (phase == 2'h1 |=> phase == 2'h2
      ##1 phase == 2'h3 ##1 phase == 2'h0) else $error("phase order");
   read_strobe_a: assert property (tf |=> file_rd_en
      && file_addr == $past(instr_word[6:0])) else $error("read strobe");
   lit_result_a: assert property (tl |-> ##4 done
      && acc == $past(instr_word[7:0], 4) - $past(acc, 4)
      && carry_flag == $past(lit_ge, 4)) else $error("literal result");
   digit_carry_a: assert property (tl |-> ##4
      half_byte_carry_flag == $past(lit_lo_ge, 4)) else $error("digit carry");
   file_acc_a: assert property (tf && !instr_word[7] |-> ##4
      !file_wr_en && acc == $past(file_rd_data, 3) - $past(acc, 4))
      else $error("to acc");
   file_reg_a: assert property (tf && instr_word[7] |-> ##4 file_wr_en
      && acc == $past(acc, 4)
      && file_wr_data == $past(file_rd_data, 3) - $past(acc, 4))
      else $error("to register");
   zero_flag_a: assert property (done |-> zero_flag ==
      ((file_wr_en ? file_wr_data : acc) == 8'h00)) else $error("zero flag");
   write_done_a: assert property (file_wr_en |-> done)
      else $error("write without done");
endmodule

// ===== bench/sub_path_tb.sv
// self-checking bench of the subtract path
`timescale 1ns/100ps
module sub_path_tb;
   logic        clock, rst_n, instr_valid, file_rd_en, file_wr_en, done;
   logic        carry_flag, half_byte_carry_flag, zero_flag;
   logic [13:0] instr_word;
   logic [7:0]  file_rd_data, file_wr_data, acc, acc_m;
   logic [6:0]  file_addr;
   logic [1:0]  phase;
   int          err_count, checked;
   sub_path uut (.clock(clock), .rst_n(rst_n), .instr_valid(instr_valid),
      .instr_word(instr_word), .file_rd_data(file_rd_data),
      .file_addr(file_addr), .file_rd_en(file_rd_en),
      .file_wr_en(file_wr_en), .file_wr_data(file_wr_data), .acc(acc),
      .carry_flag(carry_flag), .half_byte_carry_flag(half_byte_carry_flag),
      .zero_flag(zero_flag), .done(done), .phase(phase));
   always #2.5 clock = ~clock;
   task automatic chk(input string name, input logic [7:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      if (err_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one word through all four phases; busy-time valid must be ignored
   task automatic op(input logic [13:0] w, input logic [7:0] rd);
      logic [7:0] a, d;
      logic [2:0] f;
      logic       fl, sub, to_reg;
      int         n;
      fl = w[13:8] == 6'h02;
      sub = w[13:9] == 5'b11110 || fl;
      to_reg = fl && w[7];
      a = fl ? rd : w[7:0];
      d = a - acc_m;
      f = {a >= acc_m, a[3:0] >= acc_m[3:0], d == 8'h00};
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (phase !== 2'h0 && n < 8);
      if (n >= 8) begin
         err_count++;
         report_and_stop;
      end
      @(posedge clock);
      instr_valid <= 1'b1;
      instr_word <= w;
      file_rd_data <= rd;
      @(posedge clock);
      instr_word <= 14'h3CFF;
      #1;
      chk("file_rd_en", file_rd_en, fl);
      if (fl) chk("file_addr", file_addr, w[6:0]);
      @(posedge clock);
      file_rd_data <= ~rd;
      @(posedge clock);
      instr_valid <= 1'b0;
      @(posedge clock);
      #1;
      chk("done", done, sub);
      if (sub && !to_reg) acc_m = d;
      chk("acc", acc, acc_m);
      chk("file_wr_en", file_wr_en, to_reg);
      if (to_reg) chk("file_wr_data", file_wr_data, d);
      if (sub) begin
         chk("carry", carry_flag, f[2]);
         chk("digit carry", half_byte_carry_flag, f[1]);
         chk("zero", zero_flag, f[0]);
      end
   endtask
   task automatic literal_examples;
      logic [7:0] k [6] = '{8'h01, 8'h02, 8'h03, 8'h02, 8'h03, 8'h02};
      foreach (k[i]) op({6'h3C, k[i]}, 8'h00);
   endtask
   task automatic file_forms;
      op({6'h02, 1'b1, 7'h7F}, 8'h05);
      op({6'h02, 1'b0, 7'h00}, 8'h10);
      op({6'h02, 1'b1, 7'h2A}, 8'h11);
   endtask
   task automatic other_words;
      op(14'h0000, 8'hAA);
      op(14'h3800, 8'h55);
      op(14'h3005, 8'h00);
      op(14'h3D04, 8'h00);
   endtask
   initial begin
      clock = 1'b0;
      rst_n = 1'b0;
      instr_valid = 1'b0;
      instr_word = 14'h0000;
      file_rd_data = 8'h00;
      acc_m = 8'h00;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      literal_examples;
      file_forms;
      other_words;
      report_and_stop;
   end
endmodule
bind sub_path sub_path_monitor mon (.clock(clock), .rst_n(rst_n),
   .instr_valid(instr_valid), .instr_word(instr_word),
   .file_rd_data(file_rd_data), .file_addr(file_addr),
   .file_rd_en(file_rd_en), .file_wr_en(file_wr_en),
   .file_wr_data(file_wr_data), .acc(acc), .carry_flag(carry_flag),
   .half_byte_carry_flag(half_byte_carry_flag), .zero_flag(zero_flag),
   .done(done), .phase(phase));

// ===== rtl/sub_adder.sv
// eight-bit subtractor built as inverted subtrahend plus one
`timescale 1ns/100ps
module sub_adder #(
   parameter int WIDTH = 8
) (
   input  wire logic [WIDTH-1:0] minuend,
   input  wire logic [WIDTH-1:0] subtrahend,
   output      logic [WIDTH-1:0] diff,
   output      logic             no_borrow,
   output      logic             nibble_no_borrow
);
   logic [WIDTH:0] full_sum;
   logic [4:0]     low_sum;
   // two's complement: a + ~b + 1, carry out means no borrow
   always_comb begin
      full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {{WIDTH{1'b0}}, 1'b1};
      low_sum  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
      diff             = full_sum[WIDTH-1:0];
      no_borrow        = full_sum[WIDTH];
      nibble_no_borrow = low_sum[4];
   end
endmodule

// ===== rtl/sub_path.sv
// subtract instruction datapath: literal and file-register forms
`timescale 1ns/100ps
`include "sub_path_map.svh"
module sub_path
   import sub_path_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             instr_valid,
   input  wire logic [13:0]      instr_word,
   input  wire logic [WIDTH-1:0] file_rd_data,
   output      logic [6:0]       file_addr,
   output      logic             file_rd_en,
   output      logic             file_wr_en,
   output      logic [WIDTH-1:0] file_wr_data,
   output      logic [WIDTH-1:0] acc,
   output      logic             carry_flag,
   output      logic             half_byte_carry_flag,
   output      logic             zero_flag,
   output      logic             done,
   output      logic [1:0]       phase
);
   // ==========================================================
   // phase sequencer and operand state
   phase_t           phase_q;
   phase_t           phase_d;
   sub_op_t          op_q;
   sub_op_t          op_d;
   logic             dest_q;
   logic             dest_d;
   logic [6:0]       addr_q;
   logic [6:0]       addr_d;
   logic [WIDTH-1:0] opnd_q;
   logic [WIDTH-1:0] opnd_d;
   logic [WIDTH-1:0] res_q;
   logic [WIDTH-1:0] res_d;
   logic             c_res_q;
   logic             c_res_d;
   logic             dc_res_q;
   logic             dc_res_d;
   logic             rd_q;
   logic             rd_d;

   // ==========================================================
   // architectural state
   logic [WIDTH-1:0] acc_q;
   logic [WIDTH-1:0] acc_d;
   logic             c_q;
   logic             c_d;
   logic             dc_q;
   logic             dc_d;
   logic             z_q;
   logic             z_d;
   logic             wr_q;
   logic             wr_d;
   logic [WIDTH-1:0] wdata_q;
   logic [WIDTH-1:0] wdata_d;
   logic             done_q;
   logic             done_d;

   // ==========================================================
   // instruction decode
   sub_op_t          dec_op;
   logic             dec_dest;
   logic [6:0]       dec_addr;
   logic [WIDTH-1:0] dec_lit;

   always_comb begin
      dec_op   = OP_NONE;
      dec_dest = instr_word[`DEST_BIT];
      dec_addr = instr_word[`ADDR_HI:`ADDR_LO];
      dec_lit  = instr_word[`LIT_HI:`LIT_LO];
      // the top two bits count too: other literal words share 110x lower
      if ((instr_word[`OPC_LIT_HI:`OPC_LIT_LO] & `OPC_LIT_MASK)
          == `OPC_LIT_VAL) begin
         dec_op = OP_LIT;
      end else if (instr_word[`OPC_FILE_HI:`OPC_FILE_LO]
                   == `OPC_FILE_VAL) begin
         dec_op = OP_FILE;
      end
   end

   // ==========================================================
   // subtractor: operand minus accumulator
   logic [WIDTH-1:0] diff;
   logic             no_borrow;
   logic             nib_no_borrow;

   sub_adder #(.WIDTH(WIDTH)) u_sub (
      .minuend          (opnd_q),
      .subtrahend       (acc_q),
      .diff             (diff),
      .no_borrow        (no_borrow),
      .nibble_no_borrow (nib_no_borrow)
   );

   // ==========================================================
   // phase sequencer
   always_comb begin
      phase_d  = phase_q;
      op_d     = op_q;
      dest_d   = dest_q;
      addr_d   = addr_q;
      opnd_d   = opnd_q;
      res_d    = res_q;
      c_res_d  = c_res_q;
      dc_res_d = dc_res_q;
      rd_d     = 1'b0;
      unique case (phase_q)
         PH_DECODE: begin
            // idle here until a word arrives; each word takes four cycles, one per phase
            if (instr_valid) begin
               phase_d = PH_READ;
               op_d    = dec_op;
               if (dec_op == OP_LIT) begin
                  opnd_d = dec_lit;
               end else if (dec_op == OP_FILE) begin
                  dest_d = dec_dest;
                  addr_d = dec_addr;
                  rd_d   = 1'b1;
               end
            end
         end
         PH_READ: begin
            phase_d = PH_PROCESS;
            // register file answers in the same cycle as the read strobe
            if (op_q == OP_FILE) begin
               opnd_d = file_rd_data;
            end
         end
         PH_PROCESS: begin
            phase_d  = PH_WRITE;
            res_d    = diff;
            c_res_d  = no_borrow;
            dc_res_d = nib_no_borrow;
         end
         PH_WRITE: begin
            phase_d = PH_DECODE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         phase_q  <= PH_DECODE;
         op_q     <= OP_NONE;
         dest_q   <= 1'b0;
         addr_q   <= 7'h00;
         opnd_q   <= `ACC_RESET;
         res_q    <= `ACC_RESET;
         c_res_q  <= `FLAG_RESET;
         dc_res_q <= `FLAG_RESET;
         rd_q     <= 1'b0;
      end else begin
         phase_q  <= phase_d;
         op_q     <= op_d;
         dest_q   <= dest_d;
         addr_q   <= addr_d;
         opnd_q   <= opnd_d;
         res_q    <= res_d;
         c_res_q  <= c_res_d;
         dc_res_q <= dc_res_d;
         rd_q     <= rd_d;
      end
   end

   // ==========================================================
   // architectural state update
   always_comb begin
      acc_d   = acc_q;
      c_d     = c_q;
      dc_d    = dc_q;
      z_d     = z_q;
      wr_d    = 1'b0;
      wdata_d = wdata_q;
      done_d  = 1'b0;
      // flags and destination move only at the end of a subtract word
      if (phase_q == PH_WRITE && op_q != OP_NONE) begin
         done_d = 1'b1;
         c_d    = c_res_q;
         dc_d   = dc_res_q;
         z_d    = (res_q == '0);
         if (op_q == OP_FILE && dest_q) begin
            wr_d    = 1'b1;
            wdata_d = res_q;
         end else begin
            acc_d = res_q;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         acc_q   <= `ACC_RESET;
         c_q     <= `FLAG_RESET;
         dc_q    <= `FLAG_RESET;
         z_q     <= `FLAG_RESET;
         wr_q    <= 1'b0;
         wdata_q <= `ACC_RESET;
         done_q  <= 1'b0;
      end else begin
         acc_q   <= acc_d;
         c_q     <= c_d;
         dc_q    <= dc_d;
         z_q     <= z_d;
         wr_q    <= wr_d;
         wdata_q <= wdata_d;
         done_q  <= done_d;
      end
   end

   // ==========================================================
   // outputs, all straight from flip-flops
   assign file_addr            = addr_q;
   assign file_rd_en           = rd_q;
   assign file_wr_en           = wr_q;
   assign file_wr_data         = wdata_q;
   assign acc                  = acc_q;
   assign carry_flag           = c_q;
   assign half_byte_carry_flag = dc_q;
   assign zero_flag            = z_q;
   assign done                 = done_q;
   assign phase                = phase_q;
endmodule

// ===== rtl/sub_path_map.svh
// offsets, field positions, reset values and phase counts of the subtract path
`ifndef SUB_PATH_MAP_SVH
`define SUB_PATH_MAP_SVH
// opcode, destination, address and literal fields of the 14-bit program word
`define OPC_LIT_HI       13
`define OPC_LIT_LO       8
`define OPC_LIT_VAL      6'h3C
`define OPC_LIT_MASK     6'h3E
`define OPC_FILE_HI      13
`define OPC_FILE_LO      8
`define OPC_FILE_VAL     6'h02
`define DEST_BIT         7
`define ADDR_HI          6
`define ADDR_LO          0
`define LIT_HI           7
`define LIT_LO           0
// reset values and phase count
`define ACC_RESET        8'h00
`define FLAG_RESET       1'h0
`define PHASE_COUNT      4
`endif

// ===== rtl/sub_path_pkg.sv
// types shared by the subtract path
package sub_path_pkg;
   typedef enum logic [1:0] {
      PH_DECODE  = 2'b00,
      PH_READ    = 2'b01,
      PH_PROCESS = 2'b10,
      PH_WRITE   = 2'b11
   } phase_t;
   typedef enum logic [1:0] {
      OP_NONE = 2'b00,
      OP_LIT  = 2'b01,
      OP_FILE = 2'b10
   } sub_op_t;
endpackage
